//--- verilog/cdpc_pkg.sv
package cdpc_pkg;

  // Register port geometry
  localparam int unsigned CDPC_ADDR_W = 4;
  localparam int unsigned CDPC_DATA_W = 8;
  localparam int unsigned CDPC_LVL_W = 3;
  localparam int unsigned CDPC_MODE_W = 2;

  // Register offsets
  localparam logic [CDPC_ADDR_W-1:0] CDPC_CTRL_OFFSET = 4'h0;
  localparam logic [CDPC_ADDR_W-1:0] CDPC_MODE_OFFSET = 4'h1;

  // Field positions of the priority control register
  localparam int unsigned CDPC_PCE_BIT = 7;
  localparam int unsigned CDPC_XFER_LSB = 4;
  localparam int unsigned CDPC_AUTO_BIT = 3;
  localparam int unsigned CDPC_CPU_LSB = 0;

  // Field position of the interrupt control mode register
  localparam int unsigned CDPC_MODE_LSB = 0;

  // Reset values
  localparam logic [CDPC_DATA_W-1:0] CDPC_CTRL_RESET = 8'h00;
  localparam logic [CDPC_MODE_W-1:0] CDPC_MODE_RESET = 2'h0;
  localparam logic [CDPC_DATA_W-1:0] CDPC_READ_IDLE = 8'h00;

  // Interrupt control modes; the other two codes are prohibited
  localparam logic [CDPC_MODE_W-1:0] CDPC_MODE_SINGLE = 2'h0;
  localparam logic [CDPC_MODE_W-1:0] CDPC_MODE_EXTENDED = 2'h2;

  // Level codes
  localparam logic [CDPC_LVL_W-1:0] CDPC_LVL_LOWEST = 3'h0;
  localparam logic [CDPC_LVL_W-1:0] CDPC_LVL_HIGHEST = 3'h7;

endpackage

//--- verilog/cdpc_rank.sv
`timescale 1ns/1ps

// Decides whether CPU exception handling goes ahead of one transfer engine.
// A tie goes to the transfer engine so an equal setting never starves it.
module cdpc_rank (
  // Control
  input wire logic enable_in,
  // Levels
  input wire logic [cdpc_pkg::CDPC_LVL_W-1:0] cpu_level_in,
  input wire logic [cdpc_pkg::CDPC_LVL_W-1:0] engine_level_in,
  // Decision
  output logic cpu_first_out
);
  import cdpc_pkg::*;

  always_comb begin
    cpu_first_out = enable_in && (cpu_level_in > engine_level_in);
  end

endmodule

//--- verilog/cdpc_top.sv
`timescale 1ns/1ps

// Function
// - With the priority control enable bit clear, the CPU always ranks below both transfer engines.
// - With the enable bit set, the CPU level field is compared against the transfer engine levels.
// - The transfer controller level is the read/write field in bits 6 to 4, code 0 lowest and 7 highest.
// - The DMA controller level comes from that controller's channel settings, not from this register.
// - With the auto level set bit (bit 3) set, the CPU level field follows the CPU interrupt mask every cycle in modes 00 and 10, and holds in the other two.
// - With the auto level set bit clear, the CPU level field changes only on software writes.
// - While the auto level set bit is set, software writes to the CPU level bits are ignored, reads still work.
// - The CPU level is held in bits 2 to 0, code 0 lowest and 7 highest.
// - Mode 00 takes the mask from the single condition code bit, mode 10 from the three extended mask bits.
module cdpc_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [cdpc_pkg::CDPC_ADDR_W-1:0] reg_addr_in,
  input wire logic [cdpc_pkg::CDPC_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [cdpc_pkg::CDPC_DATA_W-1:0] reg_rdata_out,
  // CPU interrupt mask state
  input wire logic cond_mask_bit_in,
  input wire logic [cdpc_pkg::CDPC_LVL_W-1:0] ext_mask_level_in,
  // DMA controller channel level
  input wire logic [cdpc_pkg::CDPC_LVL_W-1:0] dma_level_in,
  // Arbitration results
  output logic cpu_over_xfer_out,
  output logic cpu_over_dma_out,
  output logic priority_enable_out,
  output logic [cdpc_pkg::CDPC_LVL_W-1:0] cpu_level_out,
  output logic [cdpc_pkg::CDPC_LVL_W-1:0] xfer_level_out
);
  import cdpc_pkg::*;

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  logic enable_reg;
  logic [CDPC_LVL_W-1:0] xfer_level_reg;
  logic auto_reg;
  logic [CDPC_LVL_W-1:0] cpu_level_reg;
  logic [CDPC_LVL_W-1:0] cpu_level_next;
  logic [CDPC_MODE_W-1:0] mode_reg;
  logic [CDPC_DATA_W-1:0] rdata_reg;
  logic cpu_over_xfer_reg;
  logic cpu_over_dma_reg;

  logic ctrl_wr;
  logic mode_wr;
  logic [CDPC_DATA_W-1:0] ctrl_value;
  logic [CDPC_DATA_W-1:0] mode_value;
  logic [CDPC_LVL_W-1:0] mask_level;
  logic mask_valid;
  logic xfer_first;
  logic dma_first;

  // Reset release through two flip-flops
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  assign ctrl_wr = reg_wr_in && (reg_addr_in == CDPC_CTRL_OFFSET);
  assign mode_wr = reg_wr_in && (reg_addr_in == CDPC_MODE_OFFSET);

  always_comb begin
    ctrl_value = CDPC_CTRL_RESET;
    ctrl_value[CDPC_PCE_BIT] = enable_reg;
    ctrl_value[CDPC_XFER_LSB +: CDPC_LVL_W] = xfer_level_reg;
    ctrl_value[CDPC_AUTO_BIT] = auto_reg;
    ctrl_value[CDPC_CPU_LSB +: CDPC_LVL_W] = cpu_level_reg;
  end

  always_comb begin
    mode_value = CDPC_READ_IDLE;
    mode_value[CDPC_MODE_LSB +: CDPC_MODE_W] = mode_reg;
  end

  // Mask source follows the interrupt control mode; prohibited modes give no valid mask
  always_comb begin
    mask_level = cpu_level_reg;
    mask_valid = 1'b0;
    if (mode_reg == CDPC_MODE_SINGLE) begin
      mask_level = cond_mask_bit_in ? CDPC_LVL_HIGHEST : CDPC_LVL_LOWEST;
      mask_valid = 1'b1;
    end else if (mode_reg == CDPC_MODE_EXTENDED) begin
      mask_level = ext_mask_level_in;
      mask_valid = 1'b1;
    end
  end

  // Auto update wins over software; a write is judged by the auto bit as it stood before it
  always_comb begin
    cpu_level_next = cpu_level_reg;
    if (auto_reg) begin
      if (mask_valid) begin
        cpu_level_next = mask_level;
      end
    end else if (ctrl_wr) begin
      cpu_level_next = reg_wdata_in[CDPC_CPU_LSB +: CDPC_LVL_W];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= CDPC_CTRL_RESET[CDPC_PCE_BIT];
      xfer_level_reg <= CDPC_CTRL_RESET[CDPC_XFER_LSB +: CDPC_LVL_W];
      auto_reg <= CDPC_CTRL_RESET[CDPC_AUTO_BIT];
    end else if (ctrl_wr) begin
      enable_reg <= reg_wdata_in[CDPC_PCE_BIT];
      xfer_level_reg <= reg_wdata_in[CDPC_XFER_LSB +: CDPC_LVL_W];
      auto_reg <= reg_wdata_in[CDPC_AUTO_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cpu_level_reg <= CDPC_CTRL_RESET[CDPC_CPU_LSB +: CDPC_LVL_W];
    end else begin
      cpu_level_reg <= cpu_level_next;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= CDPC_MODE_RESET;
    end else if (mode_wr) begin
      mode_reg <= reg_wdata_in[CDPC_MODE_LSB +: CDPC_MODE_W];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= CDPC_READ_IDLE;
    end else if (reg_rd_in && (reg_addr_in == CDPC_CTRL_OFFSET)) begin
      rdata_reg <= ctrl_value;
    end else if (reg_rd_in && (reg_addr_in == CDPC_MODE_OFFSET)) begin
      rdata_reg <= mode_value;
    end else begin
      rdata_reg <= CDPC_READ_IDLE;
    end
  end

  cdpc_rank u_rank_xfer (
    .enable_in(enable_reg),
    .cpu_level_in(cpu_level_reg),
    .engine_level_in(xfer_level_reg),
    .cpu_first_out(xfer_first)
  );

  cdpc_rank u_rank_dma (
    .enable_in(enable_reg),
    .cpu_level_in(cpu_level_reg),
    .engine_level_in(dma_level_in),
    .cpu_first_out(dma_first)
  );

  // Decisions registered so the arbiter sees glitch-free levels
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cpu_over_xfer_reg <= 1'b0;
      cpu_over_dma_reg <= 1'b0;
    end else begin
      cpu_over_xfer_reg <= xfer_first;
      cpu_over_dma_reg <= dma_first;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign cpu_over_xfer_out = cpu_over_xfer_reg;
  assign cpu_over_dma_out = cpu_over_dma_reg;
  assign priority_enable_out = enable_reg;
  assign cpu_level_out = cpu_level_reg;
  assign xfer_level_out = xfer_level_reg;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  a_low_when_off: assert property (
    !enable_reg |=> !cpu_over_xfer_out && !cpu_over_dma_out)
    else $error("CPU ranked above a transfer engine while control is off");

  a_rank_xfer: assert property (
    enable_reg |=> cpu_over_xfer_out == ($past(cpu_level_reg) > $past(xfer_level_reg)))
    else $error("CPU versus transfer controller decision wrong");

  a_rank_dma: assert property (
    enable_reg |=> cpu_over_dma_out == ($past(cpu_level_reg) > $past(dma_level_in)))
    else $error("CPU versus DMA decision wrong");

  a_xfer_field_write: assert property (
    ctrl_wr |=> xfer_level_out == $past(reg_wdata_in[CDPC_XFER_LSB +: CDPC_LVL_W]))
    else $error("Transfer controller level not written");

  a_auto_extended: assert property (
    auto_reg && (mode_reg == CDPC_MODE_EXTENDED) |=> cpu_level_out == $past(ext_mask_level_in))
    else $error("CPU level does not follow extended mask");

  a_manual_hold: assert property (
    !auto_reg && !ctrl_wr |=> $stable(cpu_level_out))
    else $error("CPU level changed without a write");

  a_manual_write: assert property (
    !auto_reg && ctrl_wr |=> cpu_level_out == $past(reg_wdata_in[CDPC_CPU_LSB +: CDPC_LVL_W]))
    else $error("CPU level write lost");

  a_write_blocked: assert property (
    auto_reg && ctrl_wr && !mask_valid |=> $stable(cpu_level_out))
    else $error("CPU level written while auto update on");

  a_read_ctrl: assert property (
    reg_rd_in && (reg_addr_in == CDPC_CTRL_OFFSET) |=> reg_rdata_out == $past(ctrl_value))
    else $error("Control register read data wrong");

  a_mode_source: assert property (
    (mode_reg != CDPC_MODE_SINGLE) && (mode_reg != CDPC_MODE_EXTENDED) && auto_reg && !ctrl_wr && !mode_wr
    |=> $stable(cpu_level_out) [*2])
    else $error("CPU level moved in a prohibited mode");

  a_auto_single: assert property (
    auto_reg && (mode_reg == CDPC_MODE_SINGLE)
    |=> cpu_level_out == ($past(cond_mask_bit_in) ? CDPC_LVL_HIGHEST : CDPC_LVL_LOWEST))
    else $error("Single mask mode level wrong");

  c_cpu_wins_xfer: cover property (enable_reg ##1 cpu_over_xfer_out);
  c_cpu_wins_dma: cover property (enable_reg ##1 cpu_over_dma_out);
  c_auto_blocked_write: cover property (auto_reg && ctrl_wr);
  c_mask_raise: cover property (auto_reg && (mode_reg == CDPC_MODE_SINGLE) && $rose(cond_mask_bit_in));

endmodule

//--- test/cdpc_partner.sv
`timescale 1ns/1ps
// Stands in for the CPU mask state and the DMA channel settings
module cdpc_partner (
  // Clock
  input wire logic mclk_in,
  // Mask state and channel level
  output logic cond_mask_bit_out,
  output logic [cdpc_pkg::CDPC_LVL_W-1:0] ext_mask_level_out,
  output logic [cdpc_pkg::CDPC_LVL_W-1:0] dma_level_out
);
  import cdpc_pkg::*;
  initial begin
    cond_mask_bit_out = 1'b0;
    ext_mask_level_out = 3'h0;
    dma_level_out = 3'h0;
  end
  // Changes land just after an edge, as the core's own registers would
  task automatic set_state(input logic c, input logic [CDPC_LVL_W-1:0] e, input logic [CDPC_LVL_W-1:0] d);
    @(posedge mclk_in);
    cond_mask_bit_out <= c;
    ext_mask_level_out <= e;
    dma_level_out <= d;
  endtask
endmodule

//--- test/tb_cpu_vs_dma_priority_control.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_cpu_vs_dma_priority_control;
  import cdpc_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic cond_m;
  logic [2:0] ext_m;
  logic [2:0] dma;
  logic ov_x;
  logic ov_d;
  logic pen;
  logic [2:0] cpu_l;
  logic [2:0] xfer_l;
  int err_count = 0;
  int n_checks = 0;
  always #12.5 mclk_in = ~mclk_in;
  cdpc_partner part_u (.mclk_in(mclk_in), .cond_mask_bit_out(cond_m), .ext_mask_level_out(ext_m),
    .dma_level_out(dma));
  cdpc_top dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .cond_mask_bit_in(cond_m),
    .ext_mask_level_in(ext_m), .dma_level_in(dma), .cpu_over_xfer_out(ov_x), .cpu_over_dma_out(ov_d),
    .priority_enable_out(pen), .cpu_level_out(cpu_l), .xfer_level_out(xfer_l));
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge mclk_in);
    #1;
    `CHK(rdata, 8'h00)
  endtask
  task automatic t_reset();
    rd_chk(CDPC_CTRL_OFFSET, CDPC_CTRL_RESET);
    rd_chk(CDPC_MODE_OFFSET, 8'h00);
    wr_reg(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00);
    rd_chk(CDPC_CTRL_OFFSET, 8'h00);
  endtask
  task automatic t_disabled();
    part_u.set_state(1'b0, 3'h0, 3'h0);
    wr_reg(CDPC_CTRL_OFFSET, 8'h07);
    @(posedge mclk_in);
    #1;
    `CHK({pen, ov_x, ov_d}, 3'b000)
  endtask
  task automatic t_rank();
    logic [2:0] c[5] = '{3'h5, 3'h3, 3'h0, 3'h7, 3'h6};
    logic [2:0] x[5] = '{3'h1, 3'h3, 3'h7, 3'h0, 3'h6};
    logic [2:0] d[5] = '{3'h4, 3'h3, 3'h0, 3'h6, 3'h7};
    for (int i = 0; i < 5; i++) begin
      part_u.set_state(1'b0, 3'h0, d[i]);
      wr_reg(CDPC_CTRL_OFFSET, {1'b1, x[i], 1'b0, c[i]});
      `CHK({xfer_l, cpu_l}, {x[i], c[i]})
      @(posedge mclk_in);
      #1;
      `CHK(ov_x, logic'(c[i] > x[i]))
      `CHK(ov_d, logic'(c[i] > d[i]))
      rd_chk(CDPC_CTRL_OFFSET, {1'b1, x[i], 1'b0, c[i]});
    end
  endtask
  task automatic t_auto();
    wr_reg(CDPC_MODE_OFFSET, {6'h00, CDPC_MODE_SINGLE});
    wr_reg(CDPC_CTRL_OFFSET, 8'h8A);
    `CHK(cpu_l, 3'h2)
    part_u.set_state(1'b1, 3'h2, 3'h6);
    @(posedge mclk_in);
    #1;
    `CHK(cpu_l, CDPC_LVL_HIGHEST)
    @(posedge mclk_in);
    #1;
    `CHK(ov_d, 1'b1)
    wr_reg(CDPC_CTRL_OFFSET, 8'h9D);
    rd_chk(CDPC_CTRL_OFFSET, 8'h9F);
    part_u.set_state(1'b0, 3'h2, 3'h6);
    @(posedge mclk_in);
    #1;
    `CHK(cpu_l, CDPC_LVL_LOWEST)
    wr_reg(CDPC_MODE_OFFSET, {6'h00, CDPC_MODE_EXTENDED});
    rd_chk(CDPC_MODE_OFFSET, 8'h02);
    part_u.set_state(1'b0, 3'h5, 3'h6);
    @(posedge mclk_in);
    #1;
    `CHK(cpu_l, 3'h5)
    // Prohibited mode code: the CPU level must freeze while the mask moves
    wr_reg(CDPC_MODE_OFFSET, 8'h01);
    part_u.set_state(1'b1, 3'h3, 3'h6);
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK(cpu_l, 3'h5)
  endtask
  task automatic t_manual();
    // The write that clears auto still has its CPU bits ignored
    wr_reg(CDPC_CTRL_OFFSET, 8'h80);
    `CHK(cpu_l, 3'h5)
    wr_reg(CDPC_CTRL_OFFSET, 8'h83);
    part_u.set_state(1'b1, 3'h6, 3'h2);
    repeat (3) @(posedge mclk_in);
    #1;
    `CHK(cpu_l, 3'h3)
    `CHK(ov_d, 1'b1)
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    err_count++;
    results();
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    t_reset();
    t_disabled();
    t_rank();
    t_auto();
    t_manual();
    results();
  end
endmodule
